// ### design/audio_route_pkg.sv
package audio_route_pkg;
  localparam int SW = 24;
  localparam int NCH = 16;
  localparam int NPATH = 4;
  localparam int NPAIR = 8;
  localparam int NDM = 5;
  localparam int NGRP = 4;
  // register map, byte addresses
  localparam logic [9:0] A_PATH_SEL = 10'h000;
  localparam logic [9:0] A_BULK = 10'h004;
  localparam logic [9:0] A_GROUP_EN = 10'h008;
  localparam logic [9:0] A_IRQ_STAT = 10'h00C;
  localparam logic [9:0] A_IRQ_MASK = 10'h010;
  localparam logic [9:0] A_PAIR_STAT = 10'h014;
  localparam logic [9:0] A_DM_SEL = 10'h018;
  localparam logic [9:0] A_OUT_DM_SEL = 10'h01C;
  // per-channel blocks: address bits [9:6] pick the block, [5:2] the channel
  localparam logic [3:0] B_CTRL = 4'h1;
  localparam logic [3:0] B_OFS = 4'h2;
  localparam logic [3:0] B_PEAK = 4'h3;
  localparam logic [3:0] B_DLY = 4'h4;
  localparam logic [3:0] B_OUT = 4'h5;
  // channel control fields
  localparam int CTL_SRC_LSB = 0;
  localparam int CTL_MUTE = 8;
  localparam int CTL_INV = 9;
  localparam int CTL_GAIN_LSB = 16;
  localparam logic [7:0] GAIN_UNITY = 8'h80;
  // input crosspoint source codes
  localparam logic [5:0] IN_DM_L = 6'h10;
  localparam logic [5:0] IN_DM_R = 6'h11;
  localparam logic [5:0] IN_FLEX0 = 6'h12;
  localparam logic [5:0] IN_SILENCE = 6'h22;
  // output crosspoint source codes
  localparam logic [5:0] OUT_AES0 = 6'h10;
  localparam logic [5:0] OUT_DM_L = 6'h20;
  localparam logic [5:0] OUT_DM_R = 6'h21;
  localparam logic [5:0] OUT_FLEX0 = 6'h22;
  localparam logic [5:0] OUT_SILENCE = 6'h32;
  // delay ranges in 0.01 ms (bulk) and 0.02 ms (offset) steps
  localparam int BULK_MIN = -3300;
  localparam int BULK_MAX = 300000;
  localparam int OFS_MIN = -40000;
  localparam int OFS_MAX = 40000;
  localparam int AUDIO_HZ = 48000;
  localparam int CLK_MHZ = 250;
  localparam int LOCK_WIN_MS = 2;
  localparam int LOCK_WIN_CYC = LOCK_WIN_MS * CLK_MHZ * 1000;
  localparam int IRQ_CLIP = 0;
  localparam int IRQ_CLASS = 1;
  localparam int IRQ_CLAMP = 2;
  typedef enum logic [1:0] {K_EMB, K_FLEX_IN, K_FLEX_OUT, K_AES} kind_t;
  typedef enum logic [1:0] {CLS_UNLOCKED, CLS_PCM, CLS_COMP, CLS_NONPCM} cls_t;
  typedef enum logic [1:0] {S_IDLE, S_BUS, S_OUT} seq_t;
  typedef struct packed {
    logic valid;
    kind_t kind;
    logic [1:0] path;
    logic [3:0] chan;
    logic nonPcm;
    logic fmtKnown;
    logic [SW-1:0] data;
  } in_word_t;
  typedef struct packed {
    logic valid;
    logic [1:0] path;
    logic [3:0] chan;
    logic [SW-1:0] data;
  } out_word_t;
  typedef struct packed {
    logic we;
    logic re;
    logic [9:0] addr;
    logic [31:0] wdata;
  } reg_req_t;
endpackage

// ### design/audio_route_delay_crosspoint.sv
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/10ps
module audio_route_delay_crosspoint #(
  parameter int DW = 12,
  parameter int AES_CHANNELS = 16,
  parameter int LOCK_WIN = audio_route_pkg::LOCK_WIN_CYC
) (
  input wire logic clock,
  input wire logic sys_rst,
  input audio_route_pkg::reg_req_t regReq,
  output logic [31:0] rdata,
  input audio_route_pkg::in_word_t inWord,
  input wire logic [3:0] rasterSubst,
  input wire logic [19:0] videoDelay,
  input wire logic [DW-1:0] maxDepth,
  output audio_route_pkg::out_word_t outWord,
  output logic irq
);
  import audio_route_pkg::*;

  typedef logic signed [SW-1:0] smp_t;

  smp_t embIn [NPATH][NCH];
  smp_t flexIn [NPATH][NCH];
  smp_t flexOut [NPATH][NCH];
  smp_t aesIn [NPATH][NCH];
  smp_t busOut [NPATH][NCH];
  smp_t dly [NPATH*NCH*(2**DW)];
  logic [NPAIR-1:0] pairNonPcm [NPATH];
  logic [NPAIR-1:0] pairFmt [NPATH];
  logic [NPAIR-1:0] pairSeen [NPATH];
  logic [NPAIR-1:0] pairLock [NPATH];
  logic [17:0] chCtrl [NPATH][NCH];
  logic signed [16:0] chOfs [NPATH][NCH];
  logic [SW-2:0] peak [NPATH][NCH];
  logic [5:0] outSel [NPATH][NCH];
  logic [19:0] dmSel [NPATH];
  logic [24:0] outDmSel [NPATH];
  logic [NGRP-1:0] groupEn [NPATH];
  cls_t clsReg [NPATH][NPAIR];
  cls_t clsNext [NPATH][NPAIR];
  logic [1:0] pathSel_reg;
  logic signed [19:0] bulk_reg;
  logic [2:0] irqStat_reg, irqStat_next, irqMask_reg;
  logic [31:0] rdata_next;
  logic [31:0] lockCnt_reg, lockCnt_next;
  seq_t st_reg, st_next;
  logic [1:0] cur_reg, cur_next;
  logic [3:0] idx_reg, idx_next;
  logic [DW-1:0] wrPtr [NPATH];
  out_word_t outWord_next;
  logic [5:0] blkCh;
  logic [3:0] rch;
  logic chWr, ofsPair, clsChg, clampEv, clipEv, lockWrap;
  logic signed [16:0] ofsWr;
  smp_t busSmp, busDly, outSmp;
  logic [DW:0] curDly;
  logic [DW+5:0] dlyWa, dlyRa;

  function automatic smp_t sat(input logic signed [SW+9:0] v);
    if (v > $signed({11'h000, {(SW-1){1'b1}}})) return {1'b0, {(SW-1){1'b1}}};
    if (v < -$signed({11'h000, {(SW-1){1'b1}}})) return {1'b1, {(SW-2){1'b0}}, 1'b1};
    return v[SW-1:0];
  endfunction

  function automatic smp_t gainOf(input smp_t s, input logic [7:0] g);
    logic signed [SW+9:0] p;
    p = (SW+10)'(s) * $signed({1'b0, g});
    return sat(p >>> 7);
  endfunction

  // halves the sum so a full-scale fold rarely clips
  function automatic smp_t fold(input smp_t a, input smp_t c, input smp_t s);
    logic signed [SW+9:0] x, y, z;
    x = (SW+10)'(a);
    y = (SW+10)'(c);
    z = (SW+10)'(s);
    return sat((x + (y >>> 1) + (y >>> 3) + (y >>> 4) + (z >>> 1) + (z >>> 3) + (z >>> 4)) >>> 1);
  endfunction

  // returns {clamped, samples}
  function automatic logic [DW:0] chanDelay(input logic signed [16:0] ofs);
    int steps, n, lim;
    steps = int'(bulk_reg) + 2 * int'(ofs) + int'(videoDelay);
    n = (steps < 0) ? 0 : steps * 12 / 25; // 0.01 ms steps to 48 kHz samples
    lim = (int'(maxDepth) < 2**DW - 1) ? int'(maxDepth) : 2**DW - 1;
    if (steps < 0) return {1'b1, {DW{1'b0}}};
    if (n > lim) return {1'b1, lim[DW-1:0]};
    return {1'b0, n[DW-1:0]};
  endfunction

  function automatic cls_t srcCls(input logic [1:0] p, input logic [5:0] sel);
    logic [2:0] pr;
    pr = sel[3:1];
    if (sel >= 6'h10) return CLS_PCM;
    if (!pairLock[p][pr]) return CLS_UNLOCKED;
    if (!pairNonPcm[p][pr]) return CLS_PCM;
    return pairFmt[p][pr] ? CLS_COMP : CLS_NONPCM;
  endfunction

  function automatic smp_t embSel(input logic [1:0] p, input logic [19:0] v, input int k);
    return embIn[p][v[4*k +: 4]];
  endfunction

  function automatic smp_t outDmSrc(input logic [1:0] p, input logic [24:0] v, input int k);
    logic [4:0] s;
    s = v[5*k +: 5];
    return s[4] ? aesIn[p][s[3:0]] : busOut[p][s[3:0]];
  endfunction

  assign blkCh = {regReq.addr[9:6], regReq.addr[5:4]};
  assign rch = regReq.addr[5:2];

  // register writes and side effects
  always_comb begin
    int w;
    w = $signed(regReq.wdata);
    chWr = regReq.we && regReq.addr[9:6] == B_OFS;
    ofsWr = 17'(w < OFS_MIN ? OFS_MIN : (w > OFS_MAX ? OFS_MAX : w));
    ofsPair = srcCls(pathSel_reg, chCtrl[pathSel_reg][rch][5:0]) inside {CLS_COMP, CLS_NONPCM};
  end

  always_ff @(posedge clock) begin
    int w;
    w = $signed(regReq.wdata);
    if (sys_rst) begin
      pathSel_reg <= 2'h0;
      bulk_reg <= 20'h00000;
      irqMask_reg <= 3'h0;
      for (int p = 0; p < NPATH; p++) begin
        groupEn[p] <= 4'hF;
        dmSel[p] <= 20'h43210;
        outDmSel[p] <= 25'h0000000;
        for (int c = 0; c < NCH; c++) begin
          chCtrl[p][c] <= {GAIN_UNITY, 4'h0, 6'(c)};
          chOfs[p][c] <= 17'sh00000;
          outSel[p][c] <= 6'(c);
        end
      end
    end else if (regReq.we) begin
      unique case (regReq.addr)
        A_PATH_SEL: pathSel_reg <= regReq.wdata[1:0];
        A_BULK: bulk_reg <= 20'(w < BULK_MIN ? BULK_MIN : (w > BULK_MAX ? BULK_MAX : w));
        A_GROUP_EN: groupEn[pathSel_reg] <= regReq.wdata[3:0];
        A_IRQ_MASK: irqMask_reg <= regReq.wdata[2:0];
        A_DM_SEL: dmSel[pathSel_reg] <= regReq.wdata[19:0];
        A_OUT_DM_SEL: outDmSel[pathSel_reg] <= regReq.wdata[24:0];
        default: begin
          if (regReq.addr[9:6] == B_CTRL)
            chCtrl[pathSel_reg][rch] <=
              {regReq.wdata[23:16], 2'h0, regReq.wdata[9:8], regReq.wdata[5:0]};
          if (regReq.addr[9:6] == B_OUT)
            outSel[pathSel_reg][rch] <= regReq.wdata[5:0];
        end
      endcase
    end
    if (!sys_rst && chWr) begin
      chOfs[pathSel_reg][rch] <= ofsWr;
      if (ofsPair)
        chOfs[pathSel_reg][rch ^ 4'h1] <= ofsWr;
    end
  end

  // input capture and pair lock tracking
  always_comb begin
    lockWrap = lockCnt_reg == 32'(LOCK_WIN - 1);
    lockCnt_next = lockWrap ? 32'h0 : lockCnt_reg + 32'h1;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      lockCnt_reg <= 32'h0;
      for (int p = 0; p < NPATH; p++) begin
        pairSeen[p] <= 8'h00;
        pairLock[p] <= 8'h00;
        pairNonPcm[p] <= 8'h00;
        pairFmt[p] <= 8'h00;
      end
    end else begin
      lockCnt_reg <= lockCnt_next;
      for (int p = 0; p < NPATH; p++) begin
        if (lockWrap) begin
          pairLock[p] <= pairSeen[p];
          pairSeen[p] <= 8'h00;
        end
      end
      if (inWord.valid && inWord.kind == K_EMB) begin
        pairSeen[inWord.path][inWord.chan[3:1]] <= 1'b1;
        pairNonPcm[inWord.path][inWord.chan[3:1]] <= inWord.nonPcm;
        pairFmt[inWord.path][inWord.chan[3:1]] <= inWord.fmtKnown;
      end
    end
    if (inWord.valid) begin
      unique case (inWord.kind)
        K_EMB: embIn[inWord.path][inWord.chan] <= inWord.data;
        K_FLEX_IN: flexIn[inWord.path][inWord.chan] <= inWord.data;
        K_FLEX_OUT: flexOut[inWord.path][inWord.chan] <= inWord.data;
        K_AES: aesIn[inWord.path][inWord.chan] <= inWord.data;
      endcase
    end
  end

  // frame sequencer: last embedded channel of a path starts a bus pass then an output pass
  always_comb begin
    logic [17:0] ctl;
    logic [5:0] src, osel;
    smp_t raw;
    ctl = chCtrl[cur_reg][idx_reg];
    src = ctl[5:0];
    raw = '0;
    if (src < IN_DM_L)
      raw = embIn[cur_reg][src[3:0]];
    else if (src == IN_DM_L)
      raw = fold(embSel(cur_reg, dmSel[cur_reg], 0), embSel(cur_reg, dmSel[cur_reg], 2),
        embSel(cur_reg, dmSel[cur_reg], 3));
    else if (src == IN_DM_R)
      raw = fold(embSel(cur_reg, dmSel[cur_reg], 1), embSel(cur_reg, dmSel[cur_reg], 2),
        embSel(cur_reg, dmSel[cur_reg], 4));
    else if (src < IN_SILENCE)
      raw = flexIn[cur_reg][4'(src - IN_FLEX0)];
    busSmp = ctl[CTL_MUTE-2] ? '0 : gainOf(ctl[CTL_INV-2] ? sat(-(SW+10)'(raw)) : raw,
      ctl[17:10]);
    curDly = chanDelay(chOfs[cur_reg][idx_reg]);
    dlyWa = {cur_reg, idx_reg, wrPtr[cur_reg]};
    dlyRa = {cur_reg, idx_reg, DW'(wrPtr[cur_reg] - curDly[DW-1:0])};
    busDly = curDly[DW-1:0] == '0 ? busSmp : dly[dlyRa];
    osel = outSel[cur_reg][idx_reg];
    outSmp = '0;
    if (osel < OUT_AES0)
      outSmp = busOut[cur_reg][osel[3:0]];
    else if (osel < OUT_DM_L)
      outSmp = (int'(osel - OUT_AES0) < AES_CHANNELS) ? aesIn[cur_reg][osel[3:0]] : '0;
    else if (osel == OUT_DM_L)
      outSmp = fold(outDmSrc(cur_reg, outDmSel[cur_reg], 0),
        outDmSrc(cur_reg, outDmSel[cur_reg], 2), outDmSrc(cur_reg, outDmSel[cur_reg], 3));
    else if (osel == OUT_DM_R)
      outSmp = fold(outDmSrc(cur_reg, outDmSel[cur_reg], 1),
        outDmSrc(cur_reg, outDmSel[cur_reg], 2), outDmSrc(cur_reg, outDmSel[cur_reg], 4));
    else if (osel < OUT_SILENCE)
      outSmp = flexOut[cur_reg][4'(osel - OUT_FLEX0)];
    st_next = st_reg;
    cur_next = cur_reg;
    idx_next = idx_reg;
    outWord_next = '0;
    clampEv = 1'b0;
    clipEv = 1'b0;
    unique case (st_reg)
      S_IDLE: begin
        if (inWord.valid && inWord.kind == K_EMB && inWord.chan == 4'hF) begin
          st_next = S_BUS;
          cur_next = inWord.path;
          idx_next = 4'h0;
        end
      end
      S_BUS: begin
        clampEv = curDly[DW];
        clipEv = busSmp[SW-1] ? busSmp == {1'b1, {(SW-2){1'b0}}, 1'b1} :
          busSmp == {1'b0, {(SW-1){1'b1}}};
        idx_next = idx_reg + 4'h1;
        if (idx_reg == 4'hF)
          st_next = S_OUT;
      end
      S_OUT: begin
        outWord_next = '{groupEn[cur_reg][idx_reg[3:2]], cur_reg, idx_reg, outSmp};
        idx_next = idx_reg + 4'h1;
        if (idx_reg == 4'hF)
          st_next = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_reg <= S_IDLE;
      cur_reg <= 2'h0;
      idx_reg <= 4'h0;
      outWord <= '0;
      for (int p = 0; p < NPATH; p++)
        wrPtr[p] <= '0;
    end else begin
      st_reg <= st_next;
      cur_reg <= cur_next;
      idx_reg <= idx_next;
      outWord <= outWord_next;
      if (st_reg == S_OUT && idx_reg == 4'hF)
        wrPtr[cur_reg] <= wrPtr[cur_reg] + DW'(1);
    end
    if (st_reg == S_BUS) begin
      dly[dlyWa] <= busSmp;
      busOut[cur_reg][idx_reg] <= busDly;
    end
  end

  // peak meters: a read clears, a new peak in the same cycle wins
  always_ff @(posedge clock) begin
    logic [SW-2:0] mag;
    mag = busSmp[SW-1] ? (SW-1)'(-busSmp) : busSmp[SW-2:0];
    if (sys_rst) begin
      for (int p = 0; p < NPATH; p++)
        for (int c = 0; c < NCH; c++)
          peak[p][c] <= '0;
    end else begin
      if (regReq.re && regReq.addr[9:6] == B_PEAK)
        peak[pathSel_reg][rch] <= '0;
      if (st_reg == S_BUS && (mag > peak[cur_reg][idx_reg] ||
          (regReq.re && regReq.addr[9:6] == B_PEAK && pathSel_reg == cur_reg && rch == idx_reg)))
        peak[cur_reg][idx_reg] <= mag;
    end
  end

  // output pair classification
  always_comb begin
    clsChg = 1'b0;
    for (int p = 0; p < NPATH; p++) begin
      for (int q = 0; q < NPAIR; q++) begin
        logic [5:0] s;
        s = outSel[p][2*q];
        clsNext[p][q] = (s < OUT_AES0) ? srcCls(2'(p), chCtrl[p][s[3:0]][5:0]) : CLS_PCM;
        if (clsNext[p][q] == CLS_UNLOCKED && rasterSubst[p])
          clsNext[p][q] = CLS_PCM;
        if (clsNext[p][q] != clsReg[p][q])
          clsChg = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    for (int p = 0; p < NPATH; p++)
      for (int q = 0; q < NPAIR; q++)
        clsReg[p][q] <= sys_rst ? CLS_UNLOCKED : clsNext[p][q];
  end

  // interrupts: sticky, write one to clear, set wins
  always_comb begin
    irqStat_next = irqStat_reg;
    if (regReq.we && regReq.addr == A_IRQ_STAT)
      irqStat_next = irqStat_reg & ~regReq.wdata[2:0];
    if (clipEv)
      irqStat_next[IRQ_CLIP] = 1'b1;
    if (clsChg)
      irqStat_next[IRQ_CLASS] = 1'b1;
    if (clampEv)
      irqStat_next[IRQ_CLAMP] = 1'b1;
  end

  // read mux, data stands one cycle after the strobe
  always_comb begin
    logic [15:0] pst;
    pst = '0;
    for (int q = 0; q < NPAIR; q++)
      pst[2*q +: 2] = clsReg[pathSel_reg][q];
    rdata_next = 32'h0;
    if (regReq.re) begin
      unique case (regReq.addr)
        A_PATH_SEL: rdata_next = {30'h0, pathSel_reg};
        A_BULK: rdata_next = 32'(bulk_reg);
        A_GROUP_EN: rdata_next = {28'h0, groupEn[pathSel_reg]};
        A_IRQ_STAT: rdata_next = {29'h0, irqStat_reg};
        A_IRQ_MASK: rdata_next = {29'h0, irqMask_reg};
        A_PAIR_STAT: rdata_next = {16'h0, pst};
        A_DM_SEL: rdata_next = {12'h0, dmSel[pathSel_reg]};
        A_OUT_DM_SEL: rdata_next = {7'h0, outDmSel[pathSel_reg]};
        default: begin
          unique case (regReq.addr[9:6])
            B_CTRL: rdata_next = {8'h0, chCtrl[pathSel_reg][rch][17:10], 6'h0,
              chCtrl[pathSel_reg][rch][7:6], 2'h0, chCtrl[pathSel_reg][rch][5:0]};
            B_OFS: rdata_next = 32'(chOfs[pathSel_reg][rch]);
            B_PEAK: rdata_next = 32'(peak[pathSel_reg][rch]);
            B_DLY: rdata_next = 32'(chanDelay(chOfs[pathSel_reg][rch]));
            B_OUT: rdata_next = {26'h0, outSel[pathSel_reg][rch]};
            default: rdata_next = 32'h0;
          endcase
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irqStat_reg <= 3'h0;
      rdata <= 32'h0;
    end else begin
      irqStat_reg <= irqStat_next;
      rdata <= rdata_next;
    end
  end

  assign irq = |(irqStat_reg & irqMask_reg);
endmodule

// ### dv/stream_source.sv
`timescale 1ns/10ps
module stream_source (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic start,
  input audio_route_pkg::kind_t kind,
  input wire logic [1:0] path,
  input wire logic nonPcm,
  input wire logic [23:0] base,
  output audio_route_pkg::in_word_t inWord,
  output logic busy
);
  import audio_route_pkg::*;
  logic [4:0] count_reg;
  logic [4:0] count_next;
  in_word_t word_next;
  assign busy = !count_reg[4];
  always_comb begin
    count_next = count_reg;
    word_next = '0;
    // idle data lines toggle so a stale sample never looks valid
    word_next.data = ~inWord.data;
    if (count_reg[4]) begin
      if (start) begin
        count_next = 5'h00;
      end
    end else begin
      // channel 15 is always the last word of a frame
      word_next.valid = 1'b1;
      word_next.kind = kind;
      word_next.path = path;
      word_next.chan = count_reg[3:0];
      word_next.nonPcm = nonPcm;
      word_next.fmtKnown = nonPcm;
      word_next.data = base + {20'h00000, count_reg[3:0]};
      count_next = count_reg + 5'h01;
    end
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      count_reg <= 5'h10;
      inWord <= '0;
    end else begin
      count_reg <= count_next;
      inWord <= word_next;
    end
  end
endmodule

// ### dv/audio_route_sva.sv
`timescale 1ns/10ps
module audio_route_sva #(
  parameter int DW = 12
) (
  input wire logic clock,
  input wire logic sys_rst,
  input audio_route_pkg::reg_req_t regReq,
  input wire logic [31:0] rdata,
  input audio_route_pkg::in_word_t inWord,
  input wire logic [3:0] rasterSubst,
  input wire logic [19:0] videoDelay,
  input wire logic [DW-1:0] maxDepth,
  input audio_route_pkg::out_word_t outWord,
  input wire logic irq
);
  import audio_route_pkg::*;
  logic [5:0] slot_reg;
  logic [5:0] slot_next;
  logic [1:0] framePath_reg;
  logic [1:0] framePath_next;
  // slot counter mirrors the sequencer: 1 in the cycle after the channel 15 word
  always_comb begin
    slot_next = slot_reg;
    framePath_next = framePath_reg;
    if (slot_reg == 6'h00) begin
      if (inWord.valid && inWord.kind == K_EMB && inWord.chan == 4'hF) begin
        slot_next = 6'h01;
        framePath_next = inWord.path;
      end
    end else if (slot_reg == 6'h21) begin
      slot_next = 6'h00;
    end else begin
      slot_next = slot_reg + 6'h01;
    end
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      slot_reg <= 6'h00;
      framePath_reg <= 2'h0;
    end else begin
      slot_reg <= slot_next;
      framePath_reg <= framePath_next;
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  a_reset_quiet:
    assert property (disable iff (1'b0) sys_rst |=> rdata == 32'h0 && outWord == '0 && !irq)
    else $error("outputs not quiet after reset");
  a_rdata_idle:
    assert property (!regReq.re |=> rdata == 32'h0)
    else $error("read data outside its cycle");
  a_unmapped_zero:
    assert property (regReq.re && regReq.addr == 10'h3FC |=> rdata == 32'h0)
    else $error("unmapped read not zero");
  a_out_slot:
    assert property (outWord.valid |-> slot_reg >= 6'h12 && slot_reg <= 6'h21
      && outWord.chan == 4'(slot_reg - 6'h12) && outWord.path == framePath_reg)
    else $error("output word outside its slot");
  a_bulk_clamp_high:
    assert property (regReq.we && regReq.addr == A_BULK && $signed(regReq.wdata) > BULK_MAX
      ##1 regReq.re && regReq.addr == A_BULK |=> rdata == 32'(BULK_MAX))
    else $error("bulk delay not clamped high");
  a_bulk_clamp_low:
    assert property (regReq.we && regReq.addr == A_BULK && $signed(regReq.wdata) < BULK_MIN
      ##1 regReq.re && regReq.addr == A_BULK |=> rdata == 32'(BULK_MIN))
    else $error("bulk delay not clamped low");
  a_offset_clamp:
    assert property (regReq.we && regReq.addr[9:6] == B_OFS && $signed(regReq.wdata) > OFS_MAX
      ##1 regReq.re && regReq.addr == $past(regReq.addr) |=> rdata == 32'(OFS_MAX))
    else $error("offset not clamped");
  a_group_readback:
    assert property (regReq.we && regReq.addr == A_GROUP_EN ##1 regReq.re
      && regReq.addr == A_GROUP_EN |=> rdata == {28'h0000000, $past(regReq.wdata[3:0], 2)})
    else $error("group enable readback wrong");
  a_irq_mask_off:
    assert property (regReq.we && regReq.addr == A_IRQ_MASK && regReq.wdata[2:0] == 3'h0
      |=> !irq)
    else $error("interrupt high with mask cleared");
endmodule
bind audio_route_delay_crosspoint audio_route_sva #(.DW(DW)) checker_i (.clock(clock),
  .sys_rst(sys_rst), .regReq(regReq), .rdata(rdata), .inWord(inWord),
  .rasterSubst(rasterSubst), .videoDelay(videoDelay), .maxDepth(maxDepth),
  .outWord(outWord), .irq(irq));

// ### dv/audio_route_delay_crosspoint_tb.sv
`timescale 1ns/10ps
module audio_route_delay_crosspoint_tb;
  import audio_route_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  reg_req_t regReq = '0;
  logic [31:0] rdata;
  in_word_t inWord;
  logic [3:0] rasterSubst = 4'h0;
  logic [19:0] videoDelay = 20'h00000;
  logic [3:0] maxDepth = 4'hF;
  out_word_t outWord;
  logic irq;
  logic start = 1'b0;
  kind_t kind = K_EMB;
  logic nonPcm = 1'b0;
  logic [23:0] base = 24'h000000;
  logic busy;
  logic [23:0] got [16];
  logic [15:0] gotMask = 16'h0000;
  logic [23:0] e;
  int fails = 0;
  int testsRun = 0;
  audio_route_delay_crosspoint #(.DW(4), .AES_CHANNELS(8), .LOCK_WIN(128)) DUT (
    .clock(clock), .sys_rst(sys_rst), .regReq(regReq), .rdata(rdata), .inWord(inWord),
    .rasterSubst(rasterSubst), .videoDelay(videoDelay), .maxDepth(maxDepth),
    .outWord(outWord), .irq(irq));
  stream_source src_i (.clock(clock), .sys_rst(sys_rst), .start(start), .kind(kind),
    .path(2'h0), .nonPcm(nonPcm), .base(base), .inWord(inWord), .busy(busy));
  initial begin
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    if (outWord.valid === 1'b1) begin
      got[outWord.chan] <= outWord.data;
      gotMask[outWord.chan] <= 1'b1;
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge clock);
    regReq <= '{1'b1, 1'b0, a, d};
    @(posedge clock);
    regReq <= '0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] x);
    @(posedge clock);
    regReq <= '{1'b0, 1'b1, a, 32'h00000000};
    @(posedge clock);
    regReq <= '0;
    #1 check($sformatf("reg %h", a), rdata, x);
  endtask
  // write then read the same address back to back
  task automatic wrrd(input logic [9:0] a, input logic [31:0] d, input logic [31:0] x);
    @(posedge clock);
    regReq <= '{1'b1, 1'b0, a, d};
    rd(a, x);
  endtask
  task automatic send(input kind_t k, input logic [23:0] b);
    @(posedge clock);
    start <= 1'b1;
    kind <= k;
    base <= b;
    @(posedge clock);
    start <= 1'b0;
    repeat (60) @(posedge clock);
  endtask
  function automatic logic [9:0] ca(input logic [3:0] b, input int c);
    return {b, c[3:0], 2'b00};
  endfunction
  task report_and_stop;
    if (fails == 0 && testsRun > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clock);
    fails++;
    report_and_stop;
  end
  initial begin
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    rd(A_PATH_SEL, 32'h00000000);
    rd(A_BULK, 32'h00000000);
    rd(A_GROUP_EN, 32'h0000000F);
    rd(A_DM_SEL, 32'h00043210);
    rd(A_OUT_DM_SEL, 32'h00000000);
    rd(A_PAIR_STAT, 32'h00000000);
    wrrd(10'h3FC, 32'hFFFFFFFF, 32'h00000000);
    for (int c = 0; c < NCH; c++) rd(ca(B_CTRL, c), 32'h00800000 | 32'(c));
    nonPcm <= 1'b1;
    wr(A_GROUP_EN, 32'h0000000E);
    wr(ca(B_CTRL, 5), 32'h00800009);
    wr(ca(B_CTRL, 11), 32'h0080010B);
    wr(ca(B_CTRL, 13), 32'h0080020D);
    wr(ca(B_CTRL, 15), 32'h00800022);
    wr(ca(B_OUT, 7), 32'h00000010);
    wr(ca(B_OUT, 9), 32'h00000018);
    send(K_AES, 24'h020000);
    repeat (2) send(K_EMB, 24'h010000);
    gotMask <= 16'h0000;
    send(K_EMB, 24'h010000);
    for (int c = 4; c < NCH; c++) begin
      e = 24'h010000 + 24'(c);
      if (c == 5) e = 24'h010009;
      if (c == 7) e = 24'h020000;
      if (c == 9 || c == 11 || c == 15) e = 24'h000000;
      if (c == 13) e = 24'h000000 - 24'h01000D;
      check($sformatf("out %0d", c), {8'h00, got[c]}, {8'h00, e});
    end
    check("group mask", {16'h0000, gotMask}, 32'h0000FFF0);
    rd(ca(B_PEAK, 0), 32'h00010000);
    rd(ca(B_PEAK, 0), 32'h00000000);
    rd(A_PAIR_STAT, 32'h0000AAAA);
    rd(A_IRQ_STAT, 32'h00000002);
    check("irq", {31'h00000000, irq}, 32'h00000000);
    wr(A_IRQ_MASK, 32'h00000002);
    #1 check("irq", {31'h00000000, irq}, 32'h00000001);
    wr(A_IRQ_STAT, 32'h00000002);
    #1 check("irq", {31'h00000000, irq}, 32'h00000000);
    rd(A_IRQ_STAT, 32'h00000000);
    wr(A_IRQ_MASK, 32'h00000000);
    wr(ca(B_OFS, 0), 32'h00000064);
    rd(ca(B_OFS, 1), 32'h00000064);
    repeat (4) @(posedge clock);
    rd(ca(B_DLY, 0), 32'h0000001F);
    rd(ca(B_DLY, 2), 32'h00000000);
    videoDelay <= 20'h00019;
    repeat (4) @(posedge clock);
    rd(ca(B_DLY, 2), 32'h0000000C);
    wr(A_BULK, 32'h00000019);
    repeat (4) @(posedge clock);
    rd(ca(B_DLY, 2), 32'h0000001F);
    wr(A_BULK, 32'hFFFFFF9C);
    repeat (4) @(posedge clock);
    rd(ca(B_DLY, 2), 32'h00000010);
    // gain down before a bulk step well over 500 ms
    wr(ca(B_CTRL, 0), 32'h00000000);
    wrrd(A_BULK, 32'h00061A80, 32'h000493E0);
    wrrd(A_BULK, 32'hFFFFEC78, 32'hFFFFF31C);
    wrrd(ca(B_OFS, 3), 32'h0000C350, 32'h00009C40);
    wr(A_PATH_SEL, 32'h00000001);
    wrrd(A_GROUP_EN, 32'h00000005, 32'h00000005);
    wr(A_PATH_SEL, 32'h00000000);
    rd(A_GROUP_EN, 32'h0000000E);
    wr(A_PATH_SEL, 32'h00000002);
    rd(A_PAIR_STAT, 32'h00000000);
    rasterSubst <= 4'h4;
    repeat (70) @(posedge clock);
    rd(A_PAIR_STAT, 32'h00005555);
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    rd(A_PATH_SEL, 32'h00000000);
    rd(A_BULK, 32'h00000000);
    report_and_stop;
  end
endmodule
